// ---- common/alrg_pkg.sv ----
// package of register map, field layout and timing tables for the auto gain block
package alrg_pkg;
  // register offsets
  localparam logic [7:0] ADDR_INPUT_SELECTOR = 8'h00;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_FORMAT_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_ZC_TIMER_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_LEFT_PEAK_LOW = 8'h04;
  localparam logic [7:0] ADDR_LEFT_PEAK_HIGH = 8'h05;
  localparam logic [7:0] ADDR_RIGHT_PEAK_LOW = 8'h06;
  localparam logic [7:0] ADDR_RIGHT_PEAK_HIGH = 8'h07;
  localparam logic [7:0] ADDR_OVERFLOW_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LIMITER_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h0A;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h0B;
  localparam logic [7:0] ADDR_RECOVERY_TIMING = 8'h0C;
  localparam logic [7:0] ADDR_RECOVERY_TARGET = 8'h0D;
  // reset values
  localparam logic [3:0] RST_INPUT_SELECTOR = 4'h5;
  localparam logic [3:0] RST_POWER_CONTROL = 4'h7;
  localparam logic [6:0] RST_FORMAT_CONTROL = 7'h00;
  localparam logic [7:0] RST_ZC_TIMER_CONTROL = 8'hE4;
  localparam logic [6:0] RST_LIMITER_CONTROL = 7'h00;
  localparam logic [6:0] RST_GAIN_CODE = 7'h10;
  localparam logic [3:0] RST_RECOVERY_TIMING = 4'h0;
  localparam logic [6:0] RST_RECOVERY_TARGET = 7'h10;
  // field positions in the zero cross and timer control register
  localparam int COMMON_GAIN_WRITE_BIT = 7;
  localparam int WRITE_TIMEOUT_LSB = 4;
  localparam int CROSSING_UPDATE_BIT = 3;
  localparam int LIMITER_TIMEOUT_LSB = 1;
  localparam int LIMITER_CROSSING_BIT = 0;
  // field positions in the limiter control register
  localparam int LIMITER_ENABLE_BIT = 7;
  localparam int RECOVERY_ENABLE_BIT = 6;
  localparam int LIMITER_THRESHOLD_LSB = 3;
  localparam int LIMITER_STEP_LSB = 0;
  // field positions in the recovery timing register
  localparam int RECOVERY_WAIT_LSB = 2;
  localparam int RECOVERY_STEP_LSB = 0;
  // timing tables, all counts in sample periods
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] WRITE_TIMEOUT_FS [0:3] = '{13'd513, 13'd1025, 13'd2049, 13'd4097};
  localparam logic [CNT_W-1:0] LIMIT_TIMEOUT_FS [0:3] = '{13'd129, 13'd258, 13'd516, 13'd1032};
  localparam logic [CNT_W-1:0] LIMIT_PERIOD_FS [0:3] = '{13'd1, 13'd2, 13'd4, 13'd8};
  localparam logic [CNT_W-1:0] RECOVERY_WAIT_FS [0:3] = '{13'd128, 13'd256, 13'd512, 13'd1024};
  // limiter thresholds on sample magnitude, and the same minus about 2 dB
  localparam logic [15:0] THRESHOLD_MAG [0:3] = '{16'h6000, 16'h5000, 16'h4000, 16'h3000};
  localparam logic [15:0] THRESHOLD_LOW_MAG [0:3] = '{16'h4C00, 16'h3F90, 16'h32E0, 16'h2620};
  // main controller states
  typedef enum logic [1:0] {ALRG_MANUAL, ALRG_READY, ALRG_ATTENUATE, ALRG_RECOVER} alrg_state_e;
endpackage : alrg_pkg

// ---- rtl/alrg_gain_stepper.sv ----
// one channel gain register that applies a new code at a zero crossing, a timeout or at once
`timescale 1ns/1ps
module alrg_gain_stepper
  import alrg_pkg::*;
#(
  parameter int GAIN_W = 7,
  parameter logic [GAIN_W-1:0] GAIN_RESET = RST_GAIN_CODE
)(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic sample_sign_in,
  input wire logic load_in,
  input wire logic [GAIN_W-1:0] target_in,
  input wire logic crossing_en_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic [GAIN_W-1:0] gain_out,
  output logic busy_out
);
  logic sign_q;
  logic busy_q;
  logic crossing;
  logic [GAIN_W-1:0] gain_q;
  logic [GAIN_W-1:0] pend_q;
  logic [CNT_W-1:0] cnt_q;
  logic en_q;
  logic [CNT_W-1:0] lim_q;

  // a sign change between two samples counts as the channel's own crossing
  assign crossing = tick_in && (sample_sign_in != sign_q);

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      sign_q <= 1'b0;
    else if (tick_in)
      sign_q <= sample_sign_in;
  end

  // pending change: a new load replaces an unapplied one, the last request wins;
  // crossing mode and limit are kept from the load, as the caller's selection drops with it
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      gain_q <= GAIN_RESET;
      pend_q <= GAIN_RESET;
      busy_q <= 1'b0;
      cnt_q <= '0;
      en_q <= 1'b0;
      lim_q <= '0;
    end
    else if (load_in)
    begin
      pend_q <= target_in;
      cnt_q <= '0;
      en_q <= crossing_en_in;
      lim_q <= limit_in;
      if (!crossing_en_in && limit_in == '0)
      begin
        gain_q <= target_in;
        busy_q <= 1'b0;
      end
      else
        busy_q <= 1'b1;
    end
    else if (busy_q && tick_in)
    begin
      cnt_q <= cnt_q + 1'b1;
      if ((en_q && crossing) || (cnt_q + 1'b1 >= lim_q))
      begin
        gain_q <= pend_q;
        busy_q <= 1'b0;
      end
    end
  end

  assign gain_out = gain_q;
  assign busy_out = busy_q;

  AST_IMMEDIATE_LOAD: assert property (@(posedge clk_in) disable iff (reset_in)
    (load_in && !crossing_en_in && limit_in == '0) |=> (gain_q == $past(target_in) && !busy_q))
    else $error("gain did not change at once with crossing update off");
  AST_WAIT_FOR_CROSSING: assert property (@(posedge clk_in) disable iff (reset_in)
    (busy_q && !load_in && !tick_in) |=> (busy_q && $stable(gain_q)))
    else $error("gain changed outside a sample tick");
endmodule : alrg_gain_stepper

// ---- rtl/alrg_controller.sv ----
// automatic limiter and recovery controller with its byte register map
// Behaviour
// - in full-auto mode host writes to the gain codes are ignored
// - input above threshold while waiting to recover starts an attenuation step
// - clearing both enables mid-step finishes that step before manual mode
// - done flag rises after at most one further step once enables clear
// - with both enables clear no attenuation happens whatever the input
// - after an attenuation the wait interval runs before any recovery step
// - wait interval ending with input below threshold minus 2dB gives one recovery step
// - each wait interval restarts at once when the previous one ends
// - input between threshold minus 2dB and threshold holds the wait timer reset
// - wait timer runs only while input is below threshold minus 2dB
// - peak hold per channel is 16 bits as low and high bytes at 04H-07H
// - gain registers hold 7-bit code and mirror done flag in bit 7
// - recovery timing register holds wait time bits 3-2, step size bits 1-0
// - recovery target register holds 7-bit target, bit 7 reads zero
// - with crossing update on, host and recovery gain changes wait for crossing or timeout, else at once
// - crossing timeout for writes and recovery is 513, 1025, 2049 or 4097 samples
// - common write: left write loads both, right write loads only right
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module alrg_controller
  import alrg_pkg::*;
#(
  parameter int GAIN_W = 7
)(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_tick_in,
  input wire logic [15:0] left_sample_in,
  input wire logic [15:0] right_sample_in,
  output logic [GAIN_W-1:0] left_gain_code_out,
  output logic [GAIN_W-1:0] right_gain_code_out,
  output logic [3:0] input_selector_out,
  output logic [3:0] power_control_out,
  output logic [6:0] format_control_out,
  output logic line_or_mic_gain_select_out
);
  alrg_state_e state_q;
  logic [3:0] input_sel_q;
  logic [3:0] power_q;
  logic [6:0] format_q;
  logic [7:0] zc_ctrl_q;
  logic [6:0] lim_ctrl_q;
  logic [3:0] rec_timing_q;
  logic [6:0] rec_target_q;
  logic [15:0] left_peak_q;
  logic [15:0] right_peak_q;
  logic [7:0] rdata_q;
  logic done_q;
  logic [CNT_W-1:0] wait_cnt_q;
  logic auto_mode;
  logic limiter_enable;
  logic recovery_enable;
  logic [1:0] limiter_threshold;
  logic [2:0] limiter_step_size;
  logic [1:0] recovery_wait_time;
  logic [1:0] recovery_step_size;
  logic crossing_update_enable;
  logic limiter_crossing_enable;
  logic common_gain_write;
  logic [15:0] left_mag;
  logic [15:0] right_mag;
  logic [15:0] level;
  logic over_threshold;
  logic under_low;
  logic [CNT_W-1:0] wait_limit;
  logic [CNT_W-1:0] write_limit;
  logic [CNT_W-1:0] att_limit;
  logic host_left_wr;
  logic host_right_wr;
  logic host_gain_ok;
  logic left_load;
  logic right_load;
  logic [GAIN_W-1:0] left_target;
  logic [GAIN_W-1:0] right_target;
  logic step_crossing_en;
  logic [CNT_W-1:0] step_limit;
  logic left_busy;
  logic right_busy;
  logic any_busy;
  logic att_issue;
  logic rec_issue;
  logic wait_end;
  logic [GAIN_W-1:0] left_gain;
  logic [GAIN_W-1:0] right_gain;
  logic [GAIN_W:0] att_left_sum;
  logic [GAIN_W:0] att_right_sum;
  logic [GAIN_W:0] rec_left_sum;
  logic [GAIN_W:0] rec_right_sum;
  logic [2:0] left_over_level;
  logic [2:0] right_over_level;

  // field decode
  assign limiter_enable = lim_ctrl_q[LIMITER_ENABLE_BIT-1];
  assign recovery_enable = lim_ctrl_q[RECOVERY_ENABLE_BIT-1];
  assign limiter_threshold = lim_ctrl_q[LIMITER_THRESHOLD_LSB +: 2];
  assign limiter_step_size = lim_ctrl_q[LIMITER_STEP_LSB +: 3];
  assign recovery_wait_time = rec_timing_q[RECOVERY_WAIT_LSB +: 2];
  assign recovery_step_size = rec_timing_q[RECOVERY_STEP_LSB +: 2];
  assign crossing_update_enable = zc_ctrl_q[CROSSING_UPDATE_BIT];
  assign limiter_crossing_enable = zc_ctrl_q[LIMITER_CROSSING_BIT];
  assign common_gain_write = zc_ctrl_q[COMMON_GAIN_WRITE_BIT];
  // only both enables together make the full-auto mode
  assign auto_mode = limiter_enable && recovery_enable;

  // level detection on the louder channel, since both channels share one sequence
  assign left_mag = left_sample_in[15] ? (~left_sample_in + 16'h0001) : left_sample_in;
  assign right_mag = right_sample_in[15] ? (~right_sample_in + 16'h0001) : right_sample_in;
  assign level = (left_mag > right_mag) ? left_mag : right_mag;
  assign over_threshold = level > THRESHOLD_MAG[limiter_threshold];
  assign under_low = level < THRESHOLD_LOW_MAG[limiter_threshold];

  // timing selections
  assign wait_limit = RECOVERY_WAIT_FS[recovery_wait_time];
  assign write_limit = crossing_update_enable ?
    WRITE_TIMEOUT_FS[zc_ctrl_q[WRITE_TIMEOUT_LSB +: 2]] : '0;
  assign att_limit = limiter_crossing_enable ?
    LIMIT_TIMEOUT_FS[zc_ctrl_q[LIMITER_TIMEOUT_LSB +: 2]] :
    LIMIT_PERIOD_FS[zc_ctrl_q[LIMITER_TIMEOUT_LSB +: 2]];
  assign any_busy = left_busy || right_busy;

  // host gain writes count only in manual mode with full-auto mode off, even with a step in flight
  assign host_gain_ok = (state_q == ALRG_MANUAL) && !auto_mode;
  assign host_left_wr = reg_wr_in && reg_addr_in == ADDR_LEFT_GAIN && host_gain_ok;
  assign host_right_wr = reg_wr_in && reg_addr_in == ADDR_RIGHT_GAIN && host_gain_ok;

  // automatic step requests, evaluated once per sample while waiting to recover
  assign wait_end = under_low && (wait_cnt_q + 1'b1 >= wait_limit);
  assign att_issue = (state_q == ALRG_READY) && auto_mode && sample_tick_in
    && over_threshold;
  assign rec_issue = (state_q == ALRG_READY) && auto_mode && sample_tick_in
    && !over_threshold && wait_end
    && (left_gain < rec_target_q || right_gain < rec_target_q);

  // new codes clamp at zero going down and at the target going up
  assign att_left_sum = {1'b0, left_gain} - {4'h0, limiter_step_size} - 8'h01;
  assign att_right_sum = {1'b0, right_gain} - {4'h0, limiter_step_size} - 8'h01;
  assign rec_left_sum = {1'b0, left_gain} + {5'h00, recovery_step_size} + 8'h01;
  assign rec_right_sum = {1'b0, right_gain} + {5'h00, recovery_step_size} + 8'h01;

  // one load per channel, from the host in manual mode or from the sequence in auto mode
  always_comb
  begin
    left_load = 1'b0;
    right_load = 1'b0;
    left_target = left_gain;
    right_target = right_gain;
    step_crossing_en = crossing_update_enable;
    step_limit = write_limit;
    if (att_issue)
    begin
      left_load = 1'b1;
      right_load = 1'b1;
      left_target = att_left_sum[GAIN_W] ? '0 : att_left_sum[GAIN_W-1:0];
      right_target = att_right_sum[GAIN_W] ? '0 : att_right_sum[GAIN_W-1:0];
      step_crossing_en = limiter_crossing_enable;
      step_limit = att_limit;
    end
    else if (rec_issue)
    begin
      left_load = 1'b1;
      right_load = 1'b1;
      left_target = (rec_left_sum > {1'b0, rec_target_q}) ? rec_target_q :
        rec_left_sum[GAIN_W-1:0];
      right_target = (rec_right_sum > {1'b0, rec_target_q}) ? rec_target_q :
        rec_right_sum[GAIN_W-1:0];
    end
    else if (host_left_wr)
    begin
      left_load = 1'b1;
      left_target = reg_wdata_in[GAIN_W-1:0];
      right_load = common_gain_write;
      right_target = reg_wdata_in[GAIN_W-1:0];
    end
    else if (host_right_wr)
    begin
      right_load = 1'b1;
      right_target = reg_wdata_in[GAIN_W-1:0];
    end
  end

  alrg_gain_stepper #(.GAIN_W(GAIN_W)) u_left_gain (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(sample_tick_in),
    .sample_sign_in(left_sample_in[15]),
    .load_in(left_load),
    .target_in(left_target),
    .crossing_en_in(step_crossing_en),
    .limit_in(step_limit),
    .gain_out(left_gain),
    .busy_out(left_busy)
  );

  alrg_gain_stepper #(.GAIN_W(GAIN_W)) u_right_gain (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(sample_tick_in),
    .sample_sign_in(right_sample_in[15]),
    .load_in(right_load),
    .target_in(right_target),
    .crossing_en_in(step_crossing_en),
    .limit_in(step_limit),
    .gain_out(right_gain),
    .busy_out(right_busy)
  );

  // sequence state: a step in flight always completes before the mode may change
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state_q <= ALRG_MANUAL;
    else
      unique case (state_q)
        ALRG_MANUAL:
          if (auto_mode && !any_busy)
            state_q <= ALRG_READY;
        ALRG_READY:
          if (!auto_mode)
            state_q <= ALRG_MANUAL;
          else if (att_issue)
            state_q <= ALRG_ATTENUATE;
          else if (rec_issue)
            state_q <= ALRG_RECOVER;
        ALRG_ATTENUATE, ALRG_RECOVER:
          if (!left_load && !any_busy)
            state_q <= auto_mode ? ALRG_READY : ALRG_MANUAL;
      endcase
  end

  // wait timer: cleared after each step, held near threshold, restarted at each end
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      wait_cnt_q <= '0;
    else if (state_q != ALRG_READY)
      wait_cnt_q <= '0;
    else if (sample_tick_in)
    begin
      if (!under_low)
        wait_cnt_q <= '0;
      else if (wait_end)
        wait_cnt_q <= '0;
      else
        wait_cnt_q <= wait_cnt_q + 1'b1;
    end
  end

  // done flag is high only once the sequence has come to rest in manual mode
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      done_q <= 1'b1;
    else
      done_q <= (state_q == ALRG_MANUAL) && !auto_mode;
  end

  // peak hold: a read of the high byte clears the channel, a louder sample still wins
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      left_peak_q <= '0;
    else if (reg_rd_in && reg_addr_in == ADDR_LEFT_PEAK_HIGH)
      left_peak_q <= sample_tick_in ? left_mag : '0;
    else if (sample_tick_in && left_mag > left_peak_q)
      left_peak_q <= left_mag;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      right_peak_q <= '0;
    else if (reg_rd_in && reg_addr_in == ADDR_RIGHT_PEAK_HIGH)
      right_peak_q <= sample_tick_in ? right_mag : '0;
    else if (sample_tick_in && right_mag > right_peak_q)
      right_peak_q <= right_mag;
  end

  // overflow level is magnitude bits 14-12 of the held peak, forced to 7 when bit 15 is set
  assign left_over_level = left_peak_q[15] ? 3'h7 : left_peak_q[14:12];
  assign right_over_level = right_peak_q[15] ? 3'h7 : right_peak_q[14:12];

  // writable control registers; full-auto mode blocks only the gain codes
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      input_sel_q <= RST_INPUT_SELECTOR;
      power_q <= RST_POWER_CONTROL;
      format_q <= RST_FORMAT_CONTROL;
      zc_ctrl_q <= RST_ZC_TIMER_CONTROL;
      lim_ctrl_q <= RST_LIMITER_CONTROL;
      rec_timing_q <= RST_RECOVERY_TIMING;
      rec_target_q <= RST_RECOVERY_TARGET;
    end
    else if (reg_wr_in)
      unique case (reg_addr_in)
        ADDR_INPUT_SELECTOR: input_sel_q <= reg_wdata_in[3:0];
        ADDR_POWER_CONTROL: power_q <= reg_wdata_in[3:0];
        ADDR_FORMAT_CONTROL: format_q <= reg_wdata_in[7:1];
        ADDR_ZC_TIMER_CONTROL: zc_ctrl_q <= reg_wdata_in;
        ADDR_LIMITER_CONTROL: lim_ctrl_q <= {reg_wdata_in[7:6], reg_wdata_in[4:0]};
        ADDR_RECOVERY_TIMING: rec_timing_q <= reg_wdata_in[3:0];
        ADDR_RECOVERY_TARGET: rec_target_q <= reg_wdata_in[6:0];
        default: ;
      endcase
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in)
  begin
    if (reset_in || !reg_rd_in)
      rdata_q <= 8'h00;
    else
      unique case (reg_addr_in)
        ADDR_INPUT_SELECTOR: rdata_q <= {4'h0, input_sel_q};
        ADDR_POWER_CONTROL: rdata_q <= {4'h0, power_q};
        ADDR_FORMAT_CONTROL: rdata_q <= {format_q, 1'b0};
        ADDR_ZC_TIMER_CONTROL: rdata_q <= zc_ctrl_q;
        ADDR_LEFT_PEAK_LOW: rdata_q <= left_peak_q[7:0];
        ADDR_LEFT_PEAK_HIGH: rdata_q <= left_peak_q[15:8];
        ADDR_RIGHT_PEAK_LOW: rdata_q <= right_peak_q[7:0];
        ADDR_RIGHT_PEAK_HIGH: rdata_q <= right_peak_q[15:8];
        ADDR_OVERFLOW_STATUS: rdata_q <= {!right_busy, !left_busy,
          right_over_level, left_over_level};
        ADDR_LIMITER_CONTROL: rdata_q <= {lim_ctrl_q[6:5], 1'b0, lim_ctrl_q[4:0]};
        ADDR_LEFT_GAIN: rdata_q <= {done_q, left_gain};
        ADDR_RIGHT_GAIN: rdata_q <= {done_q, right_gain};
        ADDR_RECOVERY_TIMING: rdata_q <= {4'h0, rec_timing_q};
        ADDR_RECOVERY_TARGET: rdata_q <= {1'b0, rec_target_q};
        default: rdata_q <= 8'h00;
      endcase
  end

  assign reg_rdata_out = rdata_q;
  assign left_gain_code_out = left_gain;
  assign right_gain_code_out = right_gain;
  assign input_selector_out = input_sel_q;
  assign power_control_out = power_q;
  assign format_control_out = format_q;
  assign line_or_mic_gain_select_out = zc_ctrl_q[6];

  // an attenuation step that runs to completion and then hands back to the ready state
  sequence s_step_finishes;
    (state_q == ALRG_ATTENUATE && !any_busy && !left_load && auto_mode) ##1
      (state_q == ALRG_READY);
  endsequence

  AST_WRITE_IGNORED: assert property (@(posedge clk_in) disable iff (reset_in)
    (auto_mode && reg_wr_in && reg_addr_in == ADDR_LEFT_GAIN && !att_issue && !rec_issue)
      |-> !left_load)
    else $error("host gain write taken in full-auto mode");
  AST_EXCEED_ATTENUATES: assert property (@(posedge clk_in) disable iff (reset_in)
    att_issue |=> (state_q == ALRG_ATTENUATE && $past(left_gain) >= left_gain))
    else $error("over threshold did not start attenuation");
  AST_STEP_FINISHES: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == ALRG_ATTENUATE && any_busy && !auto_mode) |=>
      (state_q == ALRG_ATTENUATE && !done_q))
    else $error("mode left before the step finished");
  AST_DONE_AFTER_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q != ALRG_MANUAL && !any_busy && !left_load && !auto_mode) |=> ##1 done_q)
    else $error("done flag did not rise after the last step");
  AST_NO_LIMIT_MANUAL: assert property (@(posedge clk_in) disable iff (reset_in)
    (!limiter_enable && !recovery_enable && over_threshold && !reg_wr_in) |->
      (!left_load && !right_load))
    else $error("limiter acted with both enables clear");
  AST_WAIT_AFTER_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
    s_step_finishes |-> (wait_cnt_q == '0))
    else $error("wait interval not started fresh after attenuation");
  AST_RECOVERY_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
    rec_issue |=> (state_q == ALRG_RECOVER && left_load == 1'b0))
    else $error("wait end below low threshold gave no recovery step");
  AST_WAIT_RESTART: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == ALRG_READY && auto_mode && sample_tick_in && wait_end) |=> (wait_cnt_q == '0))
    else $error("wait interval did not restart at once");
  AST_TIMER_HELD: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == ALRG_READY && sample_tick_in && !under_low && !over_threshold) |=>
      (wait_cnt_q == '0))
    else $error("wait timer ran near the threshold");
  AST_TIMER_RUNS: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == ALRG_READY && auto_mode && sample_tick_in && under_low && !wait_end) |=>
      (wait_cnt_q == $past(wait_cnt_q) + 1'b1))
    else $error("wait timer did not count below low threshold");
  AST_PEAK_HIGH_READ: assert property (@(posedge clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == ADDR_LEFT_PEAK_HIGH) |=>
      (reg_rdata_out == $past(left_peak_q[15:8])))
    else $error("left peak high byte read wrong");
  AST_GAIN_READ: assert property (@(posedge clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == ADDR_RIGHT_GAIN) |=>
      (reg_rdata_out == {$past(done_q), $past(right_gain)}))
    else $error("right gain register read wrong");
  AST_COMMON_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
    (host_left_wr && common_gain_write && !att_issue && !rec_issue) |-> right_load)
    else $error("common write did not load the right gain");
endmodule : alrg_controller

// ---- sim/alrg_host_model.sv ----
// host model that drives the gain block register port
`timescale 1ns/1ps
module alrg_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0);
  // strobes rise after an edge for one cycle; read data stand one cycle, so take them mid-cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    @(negedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(negedge clk_in);
    d = rdata_in;
  endtask : rd
endmodule : alrg_host_model

// ---- sim/alrg_controller_bench.sv ----
// self-checking bench for the auto gain controller
`timescale 1ns/1ps
module alrg_controller_bench;
  logic clk_in = 1'b0, reset_in = 1'b1, tick = 1'b0, wr, rd;
  logic [15:0] smp = 16'h0000;
  logic [7:0] ad, wd, rdt, v;
  logic [6:0] lg, rg, fmt;
  logic [3:0] isel, pwr;
  logic line_or_mic_gain_select;
  int bad_count = 0, check_count = 0;
  // clock, and a sample tick every other cycle so the auto timing stays short
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) tick <= ~tick;
  alrg_host_model host_u (.clk_in(clk_in), .rdata_in(rdt), .addr_out(ad), .wdata_out(wd),
    .wr_out(wr), .rd_out(rd));
  alrg_controller dut_u (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(ad),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdt),
    .sample_tick_in(tick), .left_sample_in(smp), .right_sample_in(smp),
    .left_gain_code_out(lg), .right_gain_code_out(rg), .input_selector_out(isel),
    .power_control_out(pwr), .format_control_out(fmt), .line_or_mic_gain_select_out(line_or_mic_gain_select));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    bad_count += int'(got !== exp);
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, v);
    chk(v, exp);
  endtask : rchk
  task automatic results;
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic sc_manual;
    int n;
    chk({isel, pwr}, 8'h57);
    chk({fmt, line_or_mic_gain_select}, 8'h01);
    rchk(8'h03, 8'hE4);
    rchk(8'h0A, 8'h90);
    host_u.wr(8'h03, 8'hC0);
    host_u.wr(8'h0A, 8'h20);
    chk({1'b0, rg}, 8'h20);
    host_u.wr(8'h0B, 8'h25);
    chk({1'b0, lg}, 8'h20);
    chk({1'b0, rg}, 8'h25);
    // crossing update on with a steady sample: the right write waits for its timeout
    host_u.wr(8'h03, 8'hC8);
    host_u.wr(8'h0B, 8'h27);
    rchk(8'h08, 8'h40);
    for (n = 0; n < 1100 && rg === 7'h25; n++)
      @(negedge clk_in);
    chk(8'(n >= 1020 && n <= 1027), 8'h01);
    chk({1'b0, rg}, 8'h27);
    host_u.wr(8'h03, 8'hC0);
  endtask : sc_manual
  task automatic sc_auto;
    rchk(8'h08, 8'hC0);
    host_u.wr(8'h09, 8'hC0);
    host_u.wr(8'h0A, 8'h31);
    chk({1'b0, lg}, 8'h20);
    @(posedge clk_in);
    smp <= 16'h7000;
    for (int i = 0; i < 200 && lg === 7'h20; i++)
      @(negedge clk_in);
    chk({1'b0, lg}, 8'h1F);
    host_u.wr(8'h09, 8'h00);
    for (int i = 0; i < 50 && (i == 0 || v[7] !== 1'b1); i++)
      host_u.rd(8'h0A, v);
    chk({7'h00, v[7]}, 8'h01);
    repeat (40) @(negedge clk_in);
    rchk(8'h0A, v);
    rchk(8'h08, 8'hFF);
    rchk(8'h05, 8'h70);
  endtask : sc_auto
  // quiet input in full-auto mode: one recovery step per 128-tick wait, back to back
  task automatic sc_recover;
    int n;
    logic [6:0] g, r;
    host_u.wr(8'h0C, 8'hF1);
    rchk(8'h0C, 8'h01);
    host_u.wr(8'h0D, 8'hFF);
    rchk(8'h0D, 8'h7F);
    @(posedge clk_in);
    smp <= 16'h0000;
    host_u.wr(8'h09, 8'hC0);
    for (int k = 0; k < 2; k++)
    begin
      g = lg;
      r = rg;
      for (n = 0; n < 400 && lg === g; n++)
        @(negedge clk_in);
      chk(8'(n >= 255 && n <= 258), 8'h01);
      chk({1'b0, lg}, {1'b0, g} + 8'h02);
      chk({1'b0, rg}, {1'b0, r} + 8'h02);
    end
  endtask : sc_recover
  // hold reset for 8 cycles, then run the scenarios
  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    sc_manual();
    sc_auto();
    sc_recover();
    results();
  end
endmodule : alrg_controller_bench
